// ---- rlv_reset_ctrl.sv ----
// reset sequencer, cause flags and low-voltage indicators
// assumes APB master on clock; comparator and pin inputs are asynchronous
`timescale 1ns/100ps
module rlv_reset_ctrl
  import rlv_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rlv_option_e voltage_option,
  input wire logic pin_as_input_option,
  input wire logic supply_low_20,
  input wire logic supply_low_24,
  input wire logic supply_low_36,
  input wire logic reset_pin_n,
  input wire logic watchdog_overflow,
  output logic system_reset,
  output logic core_run,
  output logic pc_clear,
  output logic pin_input_bit,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // synchronisers
  rlv_supply_s supply_raw;
  rlv_supply_s supply;
  logic pin_sync;
  assign supply_raw = '{below_20: supply_low_20, below_24: supply_low_24,
                        below_36: supply_low_36};

  rlv_sync #(.WIDTH(4)) u_sync ( // R16
    .clock(clock),
    .reset(reset),
    .clock_en(clock_en),
    .async_in({supply_raw, reset_pin_n}),
    .reset_value(4'h1),
    .sync_out({supply, pin_sync})
  );

  ////////////////////////////////////////////////////////////////////////
  // reset source decode
  logic pin_enabled;
  logic pin_low;
  logic pin_prev;
  logic pin_fall;
  logic lv_reset;
  logic wdt_reset;
  logic any_reset;
  logic flag_mid_en;
  logic flag_high_en;

  assign pin_enabled = !pin_as_input_option; // R14
  assign pin_low = pin_enabled && !pin_sync; // R3 R15
  assign pin_fall = pin_enabled && pin_prev && !pin_sync; // R15
  assign lv_reset = supply.below_20 // R7 R8 R9
    || (voltage_option == rlv_high && supply.below_24) // R10
    || (voltage_option == rlv_maximum && supply.below_36); // R11
  assign wdt_reset = watchdog_overflow; // R5
  assign any_reset = lv_reset || wdt_reset || pin_low;
  assign flag_mid_en = voltage_option == rlv_medium
    || voltage_option == rlv_high; // R8 R9 R10
  assign flag_high_en = voltage_option == rlv_high; // R10

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  rlv_state_e state;
  rlv_state_e next_state;
  logic [11:0] count;
  logic [11:0] next_count;
  logic [1:0] cause;
  logic [1:0] next_cause;
  logic count_done;

  assign count_done = count == RLV_CNT_ONE;

  always_comb begin
    next_state = state;
    next_count = count;
    next_cause = cause;
    if (lv_reset) begin
      next_state = rlv_st_power;
      next_count = 12'(RLV_STABLE_CYC);
      next_cause = RLV_CAUSE_POWER; // R2
    end else if ((pin_low && state != rlv_st_power)
        || (pin_fall && state == rlv_st_run)) begin
      // pin is only checked once the supply wait is over
      next_state = rlv_st_pin;
      next_count = 12'(RLV_STABLE_CYC);
      next_cause = RLV_CAUSE_PIN; // R2 R3
    end else if (wdt_reset && state == rlv_st_run) begin
      next_state = rlv_st_init; // R6
      next_count = 12'(RLV_INIT_CYC);
      next_cause = RLV_CAUSE_WDT; // R2 R5
    end else begin
      unique case (state)
        rlv_st_power: begin
          if (count_done) begin
            next_state = rlv_st_pin; // R4
          end else begin
            next_count = count - RLV_CNT_ONE;
          end
        end
        rlv_st_pin: begin
          next_state = rlv_st_init; // R3 R4
          next_count = 12'(RLV_INIT_CYC);
        end
        rlv_st_init: begin
          if (count_done) begin
            next_state = rlv_st_warm; // R4 R6
            next_count = 12'(RLV_WARM_CYC);
          end else begin
            next_count = count - RLV_CNT_ONE;
          end
        end
        rlv_st_warm: begin
          if (count_done) begin
            next_state = rlv_st_run; // R4 R6
          end else begin
            next_count = count - RLV_CNT_ONE;
          end
        end
        rlv_st_run: begin
          next_count = count;
        end
        default: begin
          next_state = rlv_st_power;
          next_count = 12'(RLV_STABLE_CYC);
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= rlv_st_power;
      count <= 12'(RLV_STABLE_CYC);
      cause <= RLV_CAUSE_POWER;
      pin_prev <= 1'b1;
    end else if (clock_en) begin
      state <= next_state;
      count <= next_count;
      cause <= next_cause;
      pin_prev <= pin_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb decode
  logic access;
  logic wr;
  logic hit_status;
  logic hit_stat;
  logic hit_mask;
  logic hit_kick;
  logic hit_any;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic [1:0] irq_event;
  logic flag_mid;
  logic flag_high;
  logic [7:0] status_byte;
  logic [31:0] next_rdata;
  logic in_init;

  assign access = psel && penable && !pready;
  assign wr = access && pwrite;
  assign hit_status = paddr == RLV_STATUS_ADDR;
  assign hit_stat = paddr == RLV_IRQ_STAT_ADDR;
  assign hit_mask = paddr == RLV_IRQ_MASK_ADDR;
  assign hit_kick = paddr == RLV_WDT_KICK_ADDR;
  assign hit_any = hit_status || hit_stat || hit_mask || hit_kick;
  assign in_init = state != rlv_st_run;
  // event 0: a reset sequence finished; event 1: below_24 with the mid flag enabled and clear
  assign irq_event = {flag_mid_en && supply.below_24 && !flag_mid,
                      state == rlv_st_warm && next_state == rlv_st_run};
  assign status_byte = {cause, flag_high, flag_mid, 4'h0}; // R2 R13
  assign next_rdata = hit_status ? {24'h0000_00, status_byte}
    : hit_stat ? {30'h0000_0000, irq_stat}
    : hit_mask ? {30'h0000_0000, irq_mask}
    : 32'h0000_0000;

  always_ff @(posedge clock) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (clock_en) begin
      pready <= access;
      pslverr <= access && !hit_any;
      prdata <= (access && !pwrite) ? next_rdata : 32'h0000_0000;
    end
  end

  // indicator flags are read-only; low-voltage reset clears them
  always_ff @(posedge clock) begin
    if (reset) begin
      flag_mid <= 1'b0;
      flag_high <= 1'b0;
    end else if (clock_en) begin
      if (lv_reset) begin
        flag_mid <= 1'b0; // R12
        flag_high <= 1'b0; // R12
      end else begin
        flag_mid <= flag_mid_en && supply.below_24; // R9 R10
        flag_high <= flag_high_en && supply.below_36; // R10
      end
    end
  end

  // sticky status, set wins over write-one-to-clear
  always_ff @(posedge clock) begin
    if (reset) begin
      irq_stat <= 2'h0;
      irq_mask <= 2'h0;
      irq <= 1'b0;
    end else if (clock_en) begin
      irq_stat <= (irq_stat & ~((wr && hit_stat) ? pwdata[1:0] : 2'h0))
        | irq_event;
      if (wr && hit_mask) begin
        irq_mask <= pwdata[1:0];
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge clock) begin
    if (reset) begin
      system_reset <= 1'b1;
      core_run <= 1'b0;
      pc_clear <= 1'b1;
      pin_input_bit <= 1'b0;
    end else if (clock_en) begin
      system_reset <= next_state != rlv_st_run; // R1
      core_run <= next_state == rlv_st_run; // R1
      pc_clear <= next_state != rlv_st_run; // R1
      pin_input_bit <= pin_as_input_option && pin_sync; // R14
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset || !clock_en);

  a_lv_forces_reset: assert property ( // R7
    lv_reset |=> system_reset && state == rlv_st_power)
    else $error("low voltage did not force reset");
  a_cause_power: assert property ( // R2
    lv_reset |=> cause == RLV_CAUSE_POWER)
    else $error("power cause not recorded");
  a_pin_hold: assert property ( // R3
    pin_low && !lv_reset && state != rlv_st_power
    |=> state == rlv_st_pin && system_reset)
    else $error("pin low did not hold reset");
  a_held_in_seq: assert property ( // R1
    in_init |-> system_reset && pc_clear && !core_run)
    else $error("core released before sequence end");
  a_wdt_cause: assert property ( // R5
    (state == rlv_st_run && wdt_reset && !lv_reset && !pin_low && !pin_fall)
    |=> state == rlv_st_init && cause == RLV_CAUSE_WDT)
    else $error("watchdog reset not taken");
  a_flags_clear: assert property ( // R12
    lv_reset |=> !flag_mid && !flag_high)
    else $error("flags not cleared by low voltage reset");
  a_high_flag_opt: assert property ( // R8
    voltage_option != rlv_high |=> !flag_high)
    else $error("high flag set under wrong option");
  a_run_clear: assert property ( // R1
    core_run |-> !pc_clear && !system_reset)
    else $error("run while held");
  a_init_order: assert property ( // R4
    state == rlv_st_pin && !any_reset |=> state == rlv_st_init)
    else $error("pin check not followed by init");
  a_pin_option: assert property ( // R14
    pin_as_input_option && !lv_reset && state == rlv_st_run
    |=> state == rlv_st_run || $past(wdt_reset))
    else $error("pin acted as reset");

  c_power_up: cover property (state == rlv_st_warm ##1 state == rlv_st_run);
  c_wdt: cover property (state == rlv_st_run ##1 state == rlv_st_init);
  c_pin: cover property (state == rlv_st_pin [*3]);

endmodule : rlv_reset_ctrl

// ---- rlv_pkg.sv ----
// package for the reset and low-voltage controller
// assumes an APB slave with 32-bit data and one clock at 100 MHz
//
// Overview of operation
// R1: any reset source halts execution, initialises registers and clears the program counter, fetch restarts at zero.
// R2: status bits 7:6 give the cause, 00 watchdog, 10 power-on or low voltage, 11 external pin, 01 reserved.
// R3: with the pin reset enabled the device stays in reset while the pin is not high.
// R4: power-on runs supply wait, pin check, register init, oscillator warm-up, then execution.
// R5: an uncleared watchdog overflow resets the system.
// R6: after a watchdog reset init and warm-up run, then execution resumes from zero.
// R7: the 2.0V reset is active under every option.
// R8: lowest option resets below 2.0V and disables both indicator flags.
// R9: medium option resets below 2.0V, mid flag follows the 2.4V level, high flag disabled.
// R10: high option resets below 2.4V, both flags follow their levels; the 2.4V reset also clears the mid flag, so under this option it never reads 1.
// R11: maximum option resets below 3.6V.
// R12: any low-voltage reset clears both indicator flags.
// R13: high flag is bit 5, mid flag bit 4, both read-only and reset to zero.
// R14: with the pin-as-input option the pin is a plain input bit and never resets.
// R15: outside circuit pulls the pin low to reset, a falling edge starts a reset.
// R16: comparator outputs and the pin are synchronised before use.
package rlv_pkg;

  typedef enum logic [1:0] {
    rlv_lowest = 2'h0,
    rlv_medium = 2'h1,
    rlv_high = 2'h2,
    rlv_maximum = 2'h3
  } rlv_option_e;

  // gray along power-up, pin check, init, warm-up, run
  typedef enum logic [2:0] {
    rlv_st_power = 3'h0,
    rlv_st_pin = 3'h1,
    rlv_st_init = 3'h3,
    rlv_st_warm = 3'h2,
    rlv_st_run = 3'h6
  } rlv_state_e;

  typedef struct packed {
    logic below_20;
    logic below_24;
    logic below_36;
  } rlv_supply_s;

  localparam logic [11:0] RLV_STATUS_INDEX = 12'h086;
  localparam logic [11:0] RLV_STATUS_ADDR = 12'h218;
  localparam logic [11:0] RLV_IRQ_STAT_ADDR = 12'h400;
  localparam logic [11:0] RLV_IRQ_MASK_ADDR = 12'h404;
  localparam logic [11:0] RLV_WDT_KICK_ADDR = 12'h408;
  localparam int RLV_CAUSE_HI = 7;
  localparam int RLV_CAUSE_LO = 6;
  localparam int RLV_FLAG_HIGH_BIT = 5;
  localparam int RLV_FLAG_MID_BIT = 4;
  localparam logic [1:0] RLV_CAUSE_WDT = 2'h0;
  localparam logic [1:0] RLV_CAUSE_POWER = 2'h2;
  localparam logic [1:0] RLV_CAUSE_PIN = 2'h3;
  localparam logic [7:0] RLV_STATUS_RESET = 8'h80;
  localparam int RLV_CLOCK_MHZ = 100;
  localparam int RLV_STABLE_US = 10;
  localparam int RLV_STABLE_CYC = RLV_STABLE_US * RLV_CLOCK_MHZ;
  localparam int RLV_INIT_CYC = 4;
  localparam int RLV_WARM_US = 40;
  localparam int RLV_WARM_CYC = RLV_WARM_US * RLV_CLOCK_MHZ;
  localparam logic [11:0] RLV_CNT_ONE = 12'h001;

endpackage : rlv_pkg

// ---- rlv_sync.sv ----
// two-stage synchroniser for asynchronous levels
// assumes a free-running clock; enable freezes it
`timescale 1ns/100ps
module rlv_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_en,
  input wire logic [WIDTH-1:0] async_in,
  input wire logic [WIDTH-1:0] reset_value,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  always_ff @(posedge clock) begin
    if (reset) begin
      stage1 <= reset_value;
      sync_out <= reset_value;
    end else if (clock_en) begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : rlv_sync

// ---- rlv_supply_model.sv ----
// supply comparators and reset pin circuit beside the controller
// assumes the bench sets the supply in millivolts and the pin pull
`timescale 1ns/100ps
module rlv_supply_model (
  input wire logic [15:0] vdd_mv,
  input wire logic pin_pull,
  output logic supply_low_20,
  output logic supply_low_24,
  output logic supply_low_36,
  output logic reset_pin_n
);
  assign supply_low_20 = vdd_mv < 16'h07d0;
  assign supply_low_24 = vdd_mv <= 16'h0960;
  assign supply_low_36 = vdd_mv <= 16'h0e10;
  // pin pulled low by the outside circuit to reset
  assign reset_pin_n = !pin_pull;
endmodule : rlv_supply_model

// ---- rlv_reset_ctrl_tb.sv ----
// self-checking bench for the reset and low-voltage controller
// assumes the supply model in front and an APB master in the bench
`timescale 1ns/100ps
module rlv_reset_ctrl_tb;
  import rlv_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, system_reset, core_run, pc_clear;
  logic pin_input_bit, irq, s20, s24, s36, pin_n;
  logic pin_pull = 1'b0;
  logic wdt = 1'b0;
  logic pin_in = 1'b0;
  logic clk_en = 1'b1;
  logic [15:0] vdd = 16'h0fa0;
  rlv_option_e opt = rlv_lowest;
  int num_errors = 0;
  int cmp_count = 0;
  always #5 clock = ~clock;
  rlv_supply_model model (.vdd_mv(vdd), .pin_pull(pin_pull),
    .supply_low_20(s20), .supply_low_24(s24), .supply_low_36(s36),
    .reset_pin_n(pin_n));
  rlv_reset_ctrl dut (.clock(clock), .reset(reset), .clock_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .voltage_option(opt),
    .pin_as_input_option(pin_in), .supply_low_20(s20),
    .supply_low_24(s24), .supply_low_36(s36), .reset_pin_n(pin_n),
    .watchdog_overflow(wdt), .system_reset(system_reset),
    .core_run(core_run), .pc_clear(pc_clear),
    .pin_input_bit(pin_input_bit), .irq(irq));
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chkb
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chkb(pready, 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd_chk(input logic [11:0] a, input logic [7:0] v);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, {24'h00_0000, v});
  endtask : rd_chk
  task wait_for(input logic want, output int n);
    n = 0;
    while (core_run !== want && n < 9000) begin
      @(posedge clock);
      n++;
    end
    chkb(core_run, want);
  endtask : wait_for
  task start(input rlv_option_e o, input logic p);
    int n;
    opt <= o;
    pin_in <= p;
    vdd <= 16'h0fa0;
    pin_pull <= 1'b0;
    reset <= 1'b1;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    chk({29'h0, system_reset, core_run, pc_clear}, 32'h0000_0005);
    wait_for(1'b1, n);
    chkb(n > RLV_STABLE_CYC + RLV_WARM_CYC, 1'b1);
  endtask : start
  // supply dip into reset, then recovery with cleared flags
  task lv_drop(input logic [15:0] mv);
    int n;
    vdd <= mv;
    wait_for(1'b0, n);
    chkb(n <= 10, 1'b1);
    rd_chk(RLV_STATUS_ADDR, 8'h80);
    vdd <= 16'h0fa0;
    wait_for(1'b1, n);
    rd_chk(RLV_STATUS_ADDR, 8'h80);
  endtask : lv_drop
  ////////////////////////////////////////////////////////////////////////
  task t_power;
    logic [31:0] q;
    logic e;
    start(rlv_lowest, 1'b0);
    rd_chk(RLV_STATUS_ADDR, 8'h80);
    apb(1'b1, RLV_STATUS_ADDR, 32'h0000_00ff, q, e);
    vdd <= 16'h08fc;
    repeat (10) @(posedge clock);
    chkb(core_run, 1'b1);
    rd_chk(RLV_STATUS_ADDR, 8'h80);
    apb(1'b1, RLV_IRQ_MASK_ADDR, 32'h0000_0001, q, e);
    repeat (3) @(posedge clock);
    chkb(irq, 1'b1);
    apb(1'b1, RLV_IRQ_STAT_ADDR, 32'h0000_0001, q, e);
    repeat (3) @(posedge clock);
    chkb(irq, 1'b0);
    apb(1'b0, 12'h7f0, 32'h0000_0000, q, e);
    chkb(e, 1'b1);
    chk(q, 32'h0000_0000);
    $display("test power finished");
  endtask : t_power
  task t_wdt;
    int n;
    wdt <= 1'b1;
    @(posedge clock);
    wdt <= 1'b0;
    wait_for(1'b0, n);
    chkb(n <= 10, 1'b1);
    wait_for(1'b1, n);
    chkb(n < RLV_STABLE_CYC + RLV_WARM_CYC, 1'b1);
    rd_chk(RLV_STATUS_ADDR, 8'h00);
    $display("test watchdog finished");
  endtask : t_wdt
  task t_pin;
    int n;
    pin_pull <= 1'b1;
    wait_for(1'b0, n);
    chkb(n <= 10, 1'b1);
    repeat (100) @(posedge clock);
    chkb(system_reset, 1'b1);
    chkb(pc_clear, 1'b1);
    pin_pull <= 1'b0;
    wait_for(1'b1, n);
    rd_chk(RLV_STATUS_ADDR, 8'hc0);
    $display("test pin finished");
  endtask : t_pin
  task t_levels;
    start(rlv_medium, 1'b0);
    vdd <= 16'h08fc;
    repeat (10) @(posedge clock);
    rd_chk(RLV_STATUS_ADDR, 8'h90);
    lv_drop(16'h076c);
    start(rlv_high, 1'b0);
    vdd <= 16'h0bb8;
    repeat (10) @(posedge clock);
    rd_chk(RLV_STATUS_ADDR, 8'ha0);
    lv_drop(16'h08fc);
    start(rlv_maximum, 1'b0);
    lv_drop(16'h0bb8);
    $display("test levels finished");
  endtask : t_levels
  task t_input;
    start(rlv_lowest, 1'b1);
    pin_pull <= 1'b1;
    repeat (10) @(posedge clock);
    chkb(core_run, 1'b1);
    chkb(pin_input_bit, 1'b0);
    pin_pull <= 1'b0;
    repeat (10) @(posedge clock);
    chkb(pin_input_bit, 1'b1);
    // enable low freezes the synchroniser and the output
    clk_en <= 1'b0;
    pin_pull <= 1'b1;
    repeat (10) @(posedge clock);
    chkb(pin_input_bit, 1'b1);
    clk_en <= 1'b1;
    repeat (10) @(posedge clock);
    chkb(pin_input_bit, 1'b0);
    $display("test input pin finished");
  endtask : t_input
  ////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    t_power();
    t_wdt();
    t_pin();
    t_levels();
    t_input();
    report_and_stop();
  end
  initial begin
    #900_000;
    num_errors++;
    report_and_stop();
  end
endmodule : rlv_reset_ctrl_tb
